// File: dv/event_source.sv
`default_nettype none
// Far-side model: event pulses on the event pin and the gate level
module event_source (
   input  wire logic       i_clk,
   input  wire logic       i_rstn,
   input  wire logic       i_go,
   input  wire logic [7:0] i_n,
   input  wire logic       i_slow,
   input  wire logic       i_gate_lvl,
   output logic            o_event,
   output logic            o_gate,
   output logic            o_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt_q;  // Pulses still to send
   logic [7:0] cnt_d;
   logic [2:0] ph_q;   // Cycles spent in the current phase
   logic [2:0] ph_d;
   logic       ev_q;   // Pin level, low between bursts
   logic       ev_d;
   logic [2:0] len;    // Slow phases exercise the synchroniser margin
   assign len = i_slow ? 3'h4 : 3'h1;
   // Each pulse is a low phase then a high phase; counted edge never changes
   always_comb begin
      cnt_d = cnt_q;
      ph_d  = ph_q;
      ev_d  = ev_q;
      if (i_go && cnt_q == 8'h00) begin
         cnt_d = i_n;
         ph_d  = 3'h0;
      end else if (cnt_q != 8'h00) begin
         if (ph_q == len) begin
            ph_d = 3'h0;
            ev_d = ~ev_q;
            if (ev_q) begin
               cnt_d = cnt_q - 8'h01;
            end
         end else begin
            ph_d = ph_q + 3'h1;
         end
      end
   end
   // Registers only
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         cnt_q <= 8'h00;
         ph_q  <= 3'h0;
         ev_q  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         ph_q  <= ph_d;
         ev_q  <= ev_d;
      end
   end
   assign o_event = ev_q;
   // Gate stays high (open) unless a scenario closes it
   assign o_gate  = i_gate_lvl;
   assign o_busy  = cnt_q != 8'h00;
endmodule
`default_nettype wire

// File: dv/timer16_cascade_tb.sv
`default_nettype none
module timer16_cascade_tb
   import timer16_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_clk    = 1'b0;  // 20 MHz
   logic        i_rstn   = 1'b0;
   logic [7:0]  awaddr   = 8'h00;
   logic [7:0]  araddr   = 8'h00;
   logic [7:0]  ev_n     = 8'h00;
   logic [31:0] wdata    = 32'h0;
   logic        awvalid  = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid  = 1'b0, rready = 1'b0;
   logic        go       = 1'b0, slow = 1'b0, gate_lvl = 1'b1;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        pin, irq_a, irq_b, ev_pin, gate_pin, busy;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata, tmp;
   logic [33:0] rq[$];            // Expected {resp, data} of reads
   logic [1:0]  bq[$];            // Expected write responses
   logic [31:0] seed     = 32'h76AC;
   int          mismatches = 0, checked = 0, ev_tot = 0, t0 = 0, m0 = 0, tk, ef;
   logic [7:0]  lv [7]   = '{8'h44, 8'h40, 8'h4C, 8'h48, 8'h40, 8'h00, 8'h40};
   logic        lp [7]   = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};

   always #25 i_clk = ~i_clk;

   timer16_cascade dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_event_input_pin(ev_pin),
      .i_gate_enable(gate_pin), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .o_timer_out_pin(pin), .o_match_a_irq(irq_a), .o_match_b_irq(irq_b));
   event_source src (.i_clk(i_clk), .i_rstn(i_rstn), .i_go(go), .i_n(ev_n), .i_slow(slow),
      .i_gate_lvl(gate_lvl), .o_event(ev_pin), .o_gate(gate_pin), .o_busy(busy));

   // Xorshift source, fixed start
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask

   // Write: address and data offered together, each released when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bit ta, tw, tb;
      @(posedge i_clk);
      bq.push_back(r);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(negedge i_clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bready && bvalid;
         @(posedge i_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
      end while (!tb);
   endtask

   // Read: expectation queued, the monitor compares
   task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bit ta, tr;
      @(posedge i_clk);
      rq.push_back({r, d});
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(negedge i_clk);
         ta = arvalid && arready;
         tr = rready && rvalid;
         @(posedge i_clk);
         if (ta) arvalid <= 1'b0;
         if (tr) rready <= 1'b0;
      end while (!tr);
   endtask

   // Sampled mid-cycle so the handshake edge is known before it comes
   always @(negedge i_clk) begin
      if (bready && bvalid) chk(34'(bresp), 34'(bq.pop_front()));
      if (rready && rvalid) chk({rresp, rdata}, rq.pop_front());
   end

   // Pin is registered behind the write, so let it land first
   task automatic pchk(input logic e);
      repeat (2) @(posedge i_clk);
      chk(34'(pin), 34'(e));
   endtask

   // Burst of n events at a random pace
   task automatic send(input int n);
      @(posedge i_clk);
      tmp = rnd();
      ev_n  <= 8'(n);
      slow  <= tmp[8];
      go    <= 1'b1;
      @(posedge i_clk);
      go    <= 1'b0;
      @(negedge i_clk);
      while (busy) @(negedge i_clk); // next burst only after this one
      repeat (6) @(posedge i_clk);
      ev_tot += n;
   endtask

   // Lower wraps every 3 events; first tick after start is swallowed
   task automatic cnt_chk();
      tk = ev_tot / 3;
      ef = (tk > 0) ? tk - 1 : 0;
      axr(OFS_COUNT16, 32'(ef % 4), RESP_OKAY);
      axr(OFS_LOWER, {16'h0, 8'(ev_tot % 3), 8'h02}, RESP_OKAY);
      axr(OFS_STATUS, {29'h0, 1'b0, ef / 4 > m0, tk > t0}, RESP_OKAY);
      pchk(((ef / 4) % 2) == 0);
      chk(34'(irq_a), 34'(ef / 4 > m0));
   endtask

   task automatic end_of_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (5) @(posedge i_clk);
      i_rstn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         axr(8'(4 * i), (i == 4) ? 32'hFF : 32'h0, RESP_OKAY);
      end
      axr(8'h18, 32'h0, RESP_SLVERR);
      axw(8'h1C, 32'h1, RESP_SLVERR);
      // Stopped: software drives the level, 00 and 11 hold it
      for (int i = 0; i < 7; i++) begin
         axw(OFS_CTRL, 32'(lv[i]), RESP_OKAY);
         pchk(lp[i]);
      end
      axw(OFS_CMP_A, 32'h3, RESP_OKAY);
      axw(OFS_CMP_B, 32'hFF, RESP_OKAY);
      axw(OFS_LOWER, 32'h2, RESP_OKAY);
      axw(OFS_CTRL, 32'hD3, RESP_OKAY);
      pchk(1'b1);
      for (int r = 0; r < 6; r++) begin
         tmp = rnd();
         send(4 + int'(tmp % 9));
         cnt_chk();
         if (r == 2) begin
            axw(OFS_STATUS, 32'h7, RESP_OKAY);
            t0 = tk;
            m0 = ef / 4;
         end
      end
      // Gate closed: events must not reach the lower counter
      axw(OFS_CTRL, 32'h1D3, RESP_OKAY);
      gate_lvl <= 1'b0;
      repeat (4) @(posedge i_clk);
      send(3);
      ev_tot -= 3;
      gate_lvl <= 1'b1;
      repeat (4) @(posedge i_clk);
      send(2);
      cnt_chk();
      axw(OFS_CTRL, 32'h40, RESP_OKAY);
      axr(OFS_COUNT16, 32'h0, RESP_OKAY);
      // Restart from a driven low level, toggling on match B only
      axw(OFS_CTRL, 32'h44, RESP_OKAY);
      pchk(1'b0);
      axw(OFS_CMP_B, 32'h1, RESP_OKAY);
      axw(OFS_CTRL, 32'hE3, RESP_OKAY);
      send(9);
      axr(OFS_COUNT16, 32'h2, RESP_OKAY);
      pchk(1'b1);
      chk(34'(irq_b), 34'(1'b1));
      end_of_test();
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge i_clk);
      mismatches++;
      end_of_test();
   end
endmodule
`default_nettype wire

// File: hdl/sync2.sv
`default_nettype none
// Two-flop synchroniser for one level
module sync2
   import timer16_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_rstn,
   input  wire logic i_async,
   output logic      o_sync
);
   logic meta_q;   // First stage, read only by the second
   logic sync_q;   // Second stage
   logic meta_d;
   logic sync_d;

   // Next values: plain shift
   always_comb begin
      meta_d = i_async;
      sync_d = meta_q;
   end

   // Registers, cleared by synchronous reset
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign o_sync = sync_q;
endmodule
`default_nettype wire

// File: hdl/timer16_cascade.sv
// Function
// - Event enable high until first gate match
// - Enable synchronised to event clock, one-count error
// - First count clock after start not counted
// - No lost count on overflow restart
// - Stopped level bits: 01 low, 10 high
// - Level bits 00 keep last pin level
// - Nonzero mode starts from established level
// - Output toggles on each match A; here a toggling match B in the same cycle cancels it
// - Start-to-match may vary one count
// - Capture read hazard; software reads after irq
// - Compares undefined after stop
// - Lower match clocks upper; upper clears on A
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`default_nettype none
module timer16_cascade
   import timer16_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_event_input_pin,
   input  wire logic        i_gate_enable,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             o_timer_out_pin,
   output logic             o_match_a_irq,
   output logic             o_match_b_irq
);
   // Synchronised pins
   logic        evt_s;          // Event input after two flops
   logic        gate_s;         // Gate enable after two flops
   // Control state
   logic [8:0]  ctrl_q, ctrl_d; // Control fields
   logic [15:0] cmpa_q, cmpa_d; // compare_capture_a, no promise kept after stop
   logic [15:0] cmpb_q, cmpb_d; // compare_capture_b
   logic [7:0]  lcmp_q, lcmp_d; // lower_compare
   // Counters and flags
   logic [7:0]  low_q, low_d;   // lower_count8
   logic [15:0] up_q, up_d;     // upper_count16
   logic        evt_q, evt_d;   // Last event level, for edge detect
   logic        lflag_q, lflag_d;   // lower_match_flag
   logic        fa_q, fa_d;     // Match A status
   logic        fb_q, fb_d;     // Match B status
   logic        out_q, out_d;   // timer_out_pin level
   start_e      st_q, st_d;     // Start synchroniser
   // Bus state
   logic        aw_q, aw_d;
   logic        w_q, w_d;
   logic [7:0]  awa_q, awa_d;
   logic [31:0] wd_q, wd_d;
   logic        bv_q, bv_d;
   logic [1:0]  br_q, br_d;
   logic        rv_q, rv_d;
   logic [31:0] rd_q, rd_d;
   logic [1:0]  rr_q, rr_d;
   // Helpers
   logic [1:0]  mode;
   logic        running;
   logic        evt_edge;
   logic        low_match;
   logic        cnt_tick;
   logic        match_a;
   logic        match_b;
   logic        wr_go;
   logic        st_clr;

   // Pins from outside are synchronised before use
   sync2 u_sync_evt (
      .i_clk   (i_clk),
      .i_rstn  (i_rstn),
      .i_async (i_event_input_pin),
      .o_sync  (evt_s)
   );
   // Gate is resampled in this domain, hence up to one count of error
   sync2 u_sync_gate (
      .i_clk   (i_clk),
      .i_rstn  (i_rstn),
      .i_async (i_gate_enable),
      .o_sync  (gate_s)
   );

   assign mode    = ctrl_q[CTRL_MODE_LSB +: 2];
   assign running = (mode != MODE_STOP);
   // Rising event edge counts only while the gate is open or gating is off
   assign evt_edge  = evt_s && !evt_q && ctrl_q[CTRL_LRUN_BIT]
                      && (gate_s || !ctrl_q[CTRL_GATE_BIT]);
   assign low_match = evt_edge && (low_q == lcmp_q);
   // Upper count clock is the lower match, taken only synchronised and running
   assign cnt_tick  = low_match && (st_q == ST_RUN) && running;
   assign match_a   = cnt_tick && (up_q == cmpa_q);
   assign match_b   = cnt_tick && (up_q == cmpb_q);
   assign wr_go     = aw_q && w_q && !bv_q;
   assign st_clr    = wr_go && (awa_q == OFS_STATUS);

   // Start synchroniser: first count clock after start is swallowed
   always_comb begin
      case (st_q)
         ST_IDLE:  st_d = !running ? ST_IDLE : (low_match ? ST_RUN : ST_ARMED);
         ST_ARMED: st_d = !running ? ST_IDLE :
                          (low_match ? ST_RUN : ST_ARMED);
         ST_RUN:   st_d = running ? ST_RUN : ST_IDLE; // stays synced
         default:  st_d = ST_IDLE;
      endcase
   end

   // Counters, flags and output level
   always_comb begin
      evt_d   = evt_s;
      low_d   = low_q;
      up_d    = up_q;
      lflag_d = lflag_q;
      fa_d    = fa_q;
      fb_d    = fb_q;
      out_d   = out_q;
      // Lower counter clears when it matches its compare
      if (!ctrl_q[CTRL_LRUN_BIT]) begin
         low_d = 8'h00;
      end else if (evt_edge) begin
         low_d = low_match ? 8'h00 : low_q + 8'h01;
      end
      // Upper counter clears on match A, wraps freely otherwise
      if (!running) begin
         up_d = COUNT_RST;
      end else if (cnt_tick) begin
         up_d = match_a ? COUNT_RST : up_q + 16'h0001;
      end
      // Software clears first, so a same-cycle event wins
      if (st_clr && wd_q[ST_LMATCH_BIT]) begin
         lflag_d = 1'b0;
      end
      if (st_clr && wd_q[ST_MA_BIT]) begin
         fa_d = 1'b0;
      end
      if (st_clr && wd_q[ST_MB_BIT]) begin
         fb_d = 1'b0;
      end
      if (low_match) begin
         lflag_d = 1'b1;
      end
      if (match_a) begin
         fa_d = 1'b1;
      end
      if (match_b) begin
         fb_d = 1'b1;
      end
      // Level bits steer the pin only while stopped
      if (!running) begin
         case ({ctrl_q[CTRL_LVS_BIT], ctrl_q[CTRL_LVR_BIT]})
            2'b01:   out_d = 1'b0;
            2'b10:   out_d = 1'b1;
            default: out_d = out_q; // 00 holds, 11 ignored
         endcase
      end else begin
         // Running starts from the held level
         if (match_a && ctrl_q[CTRL_TOGA_BIT]) begin
            out_d = !out_d;
         end
         if (match_b && ctrl_q[CTRL_TOGB_BIT]) begin
            out_d = !out_d;
         end
      end
   end

   // Register file and AXI4-Lite slave
   always_comb begin
      ctrl_d = ctrl_q;
      cmpa_d = cmpa_q;
      cmpb_d = cmpb_q;
      lcmp_d = lcmp_q;
      aw_d   = aw_q;
      w_d    = w_q;
      awa_d  = awa_q;
      wd_d   = wd_q;
      bv_d   = bv_q;
      br_d   = br_q;
      rv_d   = rv_q;
      rd_d   = rd_q;
      rr_d   = rr_q;
      // Address and data are latched independently
      if (s_axi_awvalid && !aw_q) begin
         aw_d  = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
         w_d  = 1'b1;
         wd_d = s_axi_wdata;
      end
      if (wr_go) begin
         aw_d = 1'b0;
         w_d  = 1'b0;
         bv_d = 1'b1;
         br_d = RESP_OKAY;
         // Byte lanes are not split: each register takes the whole word
         case (awa_q)
            OFS_CTRL:   ctrl_d = wd_q[8:0]; // level bits held by software
            OFS_CMP_A:  cmpa_d = wd_q[15:0];
            OFS_CMP_B:  cmpb_d = wd_q[15:0];
            OFS_LOWER:  lcmp_d = wd_q[7:0];
            OFS_STATUS: br_d = RESP_OKAY;
            default:    br_d = RESP_SLVERR;
         endcase
      end
      if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      // Read returns live state; no capture path, so no read race
      if (s_axi_arvalid && !rv_q) begin
         rv_d = 1'b1;
         rr_d = RESP_OKAY;
         case (s_axi_araddr)
            OFS_CTRL:    rd_d = {23'h000000, ctrl_q};
            OFS_CMP_A:   rd_d = {16'h0000, cmpa_q};
            OFS_CMP_B:   rd_d = {16'h0000, cmpb_q};
            OFS_COUNT16: rd_d = {16'h0000, up_q}; // software corrects
            OFS_LOWER:   rd_d = {16'h0000, low_q, lcmp_q};
            OFS_STATUS:  rd_d = {29'h00000000, fb_q, fa_q, lflag_q};
            default: begin
               rd_d = 32'h00000000;
               rr_d = RESP_SLVERR;
            end
         endcase
      end else if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
   end
   // All state registered here
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         ctrl_q  <= 9'h000;
         cmpa_q  <= CMP_RST;
         cmpb_q  <= CMP_RST;
         lcmp_q  <= LCMP_RST;
         low_q   <= 8'h00;
         up_q    <= COUNT_RST;
         evt_q   <= 1'b0;
         lflag_q <= 1'b0;
         fa_q    <= 1'b0;
         fb_q    <= 1'b0;
         out_q   <= 1'b0;
         st_q    <= ST_IDLE;
         aw_q    <= 1'b0;
         w_q     <= 1'b0;
         awa_q   <= 8'h00;
         wd_q    <= 32'h00000000;
         bv_q    <= 1'b0;
         br_q    <= RESP_OKAY;
         rv_q    <= 1'b0;
         rd_q    <= 32'h00000000;
         rr_q    <= RESP_OKAY;
      end else begin
         ctrl_q  <= ctrl_d;
         cmpa_q  <= cmpa_d;
         cmpb_q  <= cmpb_d;
         lcmp_q  <= lcmp_d;
         low_q   <= low_d;
         up_q    <= up_d;
         evt_q   <= evt_d;
         lflag_q <= lflag_d;
         fa_q    <= fa_d;
         fb_q    <= fb_d;
         out_q   <= out_d;
         st_q    <= st_d;
         aw_q    <= aw_d;
         w_q     <= w_d;
         awa_q   <= awa_d;
         wd_q    <= wd_d;
         bv_q    <= bv_d;
         br_q    <= br_d;
         rv_q    <= rv_d;
         rd_q    <= rd_d;
         rr_q    <= rr_d;
      end
   end
   // Outputs; pin is forced low when the output is disabled
   assign o_timer_out_pin = out_q && ctrl_q[CTRL_OEN_BIT];
   assign o_match_a_irq   = fa_q;
   assign o_match_b_irq   = fb_q;
   assign s_axi_awready   = !aw_q;
   assign s_axi_wready    = !w_q;
   assign s_axi_bvalid    = bv_q;
   assign s_axi_bresp     = br_q;
   assign s_axi_arready   = !rv_q;
   assign s_axi_rvalid    = rv_q;
   assign s_axi_rdata     = rd_q;
   assign s_axi_rresp     = rr_q;
   // Checks
   chk_first_swallow: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (st_q == ST_ARMED && low_match) |=> (up_q == $past(up_q)))
      else $error("first count after start was counted");
   chk_upper_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
      match_a |=> (up_q == 16'h0000) && fa_q)
      else $error("upper did not clear on match A");
   chk_no_lost: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (cnt_tick && !match_a && running) |=> (up_q == $past(up_q) + 16'h0001))
      else $error("count lost while running");
   chk_level_low: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (!running && ctrl_q[3:2] == 2'b01) |=> !out_q)
      else $error("level clear did not drive low");
   chk_level_high: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (!running && ctrl_q[3:2] == 2'b10) |=> out_q)
      else $error("level set did not drive high");
   chk_level_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (!running && ctrl_q[3:2] == 2'b00) |=> $stable(out_q))
      else $error("pin changed with level bits 00");
   chk_toggle_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (match_a && ctrl_q[4] && !(match_b && ctrl_q[5])) |=> (out_q != $past(out_q)))
      else $error("no toggle on match A");
   chk_lflag_sticky: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (lflag_q && !st_clr) |=> lflag_q)
      else $error("lower flag dropped without clear");
   chk_lower_wrap: assert property (@(posedge i_clk) disable iff (!i_rstn)
      low_match |=> (low_q == 8'h00) && lflag_q)
      else $error("lower did not clear on match");
endmodule
`default_nettype wire

// File: hdl/timer16_pkg.sv
`default_nettype none
package timer16_pkg;
   // Register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_CMP_A    = 8'h04;
   localparam logic [7:0] OFS_CMP_B    = 8'h08;
   localparam logic [7:0] OFS_COUNT16  = 8'h0C;
   localparam logic [7:0] OFS_LOWER    = 8'h10;
   localparam logic [7:0] OFS_STATUS   = 8'h14;
   // Control register field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_LVR_BIT  = 2;
   localparam int CTRL_LVS_BIT  = 3;
   localparam int CTRL_TOGA_BIT = 4;
   localparam int CTRL_TOGB_BIT = 5;
   localparam int CTRL_OEN_BIT  = 6;
   localparam int CTRL_LRUN_BIT = 7;
   localparam int CTRL_GATE_BIT = 8;
   // Status register field positions
   localparam int ST_LMATCH_BIT = 0;
   localparam int ST_MA_BIT     = 1;
   localparam int ST_MB_BIT     = 2;
   // Values after reset
   localparam logic [15:0] CMP_RST   = 16'h0000;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [7:0]  LCMP_RST  = 8'hFF;
   localparam logic [1:0]  MODE_STOP = 2'b00;
   // AXI response codes
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Start synchroniser states, Gray along the path
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ARMED = 2'b01,
      ST_RUN   = 2'b11
   } start_e;
endpackage
`default_nettype wire
